// [rtl/oac_pkg.sv]
// Constants of the acquisition control block.
// Assumes one 25 MHz clock that all counts derive from.
package oac_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h00;
    localparam logic [7:0] OFS_FIFO_CFG = 8'h08;
    localparam logic [7:0] OFS_MODE_ONE = 8'h09;
    localparam logic [7:0] OFS_MODE_TWO = 8'h0A;
    localparam logic [7:0] OFS_EMIT1_AMP = 8'h0C;
    localparam logic [7:0] OFS_EMIT_SPAN = 8'h11;
    localparam logic [7:0] OFS_LOW_PWR_AMP = 8'h12;
    localparam logic [7:0] OFS_SEQ_ONE = 8'h13;
    localparam logic [7:0] OFS_SEQ_TWO = 8'h14;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int BIT_SHUTDOWN = 7;
    localparam int BIT_SOFT_RESET = 6;
    localparam int BIT_AMB_DETECT = 2;
    localparam logic [7:0] MODE_ONE_WMASK = 8'hDF;
    localparam logic [7:0] FIFO_CFG_RST = 8'h0F;
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic SUPPLY_FLAG_RST = 1'b1;
    localparam logic [5:0] FIFO_DEPTH = 6'h20;

    // ------------------------------------------------------------
    // Operating modes and slot codes
    // ------------------------------------------------------------
    localparam logic [1:0] MODE_OFF = 2'h0;
    localparam logic [1:0] MODE_SINGLE = 2'h1;
    localparam logic [1:0] MODE_DUAL = 2'h2;
    localparam logic [1:0] MODE_FLEX = 2'h3;
    localparam logic [3:0] SLOT_OFF = 4'h0;
    localparam logic [3:0] SLOT_EMIT1 = 4'h1;
    localparam logic [3:0] SLOT_EMIT2 = 4'h2;
    localparam logic [3:0] SLOT_LAST_DIRECT = 4'h4;
    localparam logic [3:0] SLOT_LAST_LOW_PWR = 4'h8;

    // ------------------------------------------------------------
    // Timing: rates in samples/s, widths in microseconds
    // ------------------------------------------------------------
    localparam int RATE_SPS [8] = '{50, 100, 200, 400, 800, 1000, 1600, 3200};
    localparam int PULSE_US [4] = '{70, 120, 220, 420};
    localparam int INTEG_US [4] = '{50, 100, 200, 400};
    localparam int SRST_CYCLES = 8;

    typedef enum logic [1:0] {
        OAC_IDLE = 2'b00,
        OAC_PULSE = 2'b01,
        OAC_NEXT = 2'b10
    } oac_state_t;

endpackage

// [rtl/oac_rate_timer.sv]
// Sample-rate tick for the slot sequencer.
// Assumes run is low while the oscillator is stopped.
`timescale 1ns/100ps
module oac_rate_timer #(
    parameter int CLK_HZ = 25000000
) (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // Control
    input wire logic run_in,
    input wire logic [2:0] rate_sel_in,
    // Tick
    output logic tick_out
);

    logic [19:0] cnt;
    logic [19:0] next_cnt;
    logic next_tick;
    logic [19:0] period;

    // ------------------------------------------------------------
    // Period lookup and counter
    // ------------------------------------------------------------
    // RULE9: code to rate
    always_comb begin
        period = 20'(CLK_HZ / oac_pkg::RATE_SPS[rate_sel_in]);
        next_cnt = cnt;
        next_tick = 1'b0;
        if (!run_in) begin
            next_cnt = 20'h00000;
        end else if (cnt >= period - 20'h00001) begin
            next_cnt = 20'h00000;
            next_tick = 1'b1;
        end else begin
            next_cnt = cnt + 20'h00001;
        end
    end

    // Register stage
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            cnt <= 20'h00000;
            tick_out <= 1'b0;
        end else begin
            cnt <= next_cnt;
            tick_out <= next_tick;
        end
    end

    // RULE9: tick spacing
    AST_TICK_SPACING: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        tick_out |=> !tick_out) // RULE9
        else $error("two ticks back to back");

endmodule

// [rtl/oac_acq_ctrl.sv]
// Acquisition control: mode registers, soft reset, shutdown, flags
// and the emitter slot sequencer.
// Assumes register strobes and FIFO count come from same-clock logic.
//
// What this block does
// RULE1: Almost-full sets when unread samples reach 32 minus the level field.
// RULE2: Shutdown enters power-save; registers stay accessible and kept.
// RULE3: Power-save entry clears flags and stops oscillator and acquisition.
// RULE4: Soft reset restores every register except the supply flag; here the almost-full flag is kept as well.
// RULE5: The soft reset bit self-clears when its sequence ends.
// RULE6: Ambient detect mode disables the cancel loop and digital filter.
// RULE7: The mode field picks off, emitter 1, emitters 1 then 2, or the slot list.
// RULE8: The span field selects full scale from 4096 nA doubling to 32768 nA.
// RULE9: Rate codes 0 to 7 select 50 up to 3200 samples per second.
// RULE10: The host keeps the rate within the pulse width and emitter count limit.
// RULE11: Pulse width codes give 70, 120, 220, 420 us pulses with 50 to 400 us integration; here emitter and integrate stay on one clock less.
// RULE12: Results carry 19 bits for every pulse width.
// RULE13: Emitter current is amplitude code times span LSB, zero gives none.
// RULE14: A raised flag stays until the host reads the status register.
// RULE15: In flex mode four slot fields choose emitter or low-power variant and order.
// RULE16: The host writes zero to reserved bits and ignores them on read.
`timescale 1ns/100ps
module oac_acq_ctrl #(
    parameter int CLK_MHZ = 25
) (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // Register access
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    // Status sources
    input wire logic [5:0] fifo_count_in,
    input wire logic supply_low_in,
    input wire logic [18:0] conv_data_in,
    // Analog and sequencing controls
    output logic osc_run_out,
    output logic ambient_cancel_loop_out,
    output logic filter_en_out,
    output logic [1:0] converter_span_sel_out,
    output logic [3:0] emitter_on_out,
    output logic [7:0] emitter_amplitude_out,
    output logic [1:0] emitter_current_span_out,
    output logic integrate_out,
    output logic [18:0] result_out,
    output logic result_valid_out,
    output logic afull_flag_out,
    output logic supply_ok_flag_out
);

    localparam int SRST_HOLD = oac_pkg::SRST_CYCLES;

    logic [7:0] fifo_cfg, mode_one, mode_two, emit_span, low_pwr_amp, seq_one, seq_two;
    logic [7:0] amp [4];
    logic [7:0] next_fifo_cfg, next_mode_one, next_mode_two, next_emit_span;
    logic [7:0] next_low_pwr_amp, next_seq_one, next_seq_two;
    logic [7:0] next_amp [4];
    logic [3:0] srst_cnt, next_srst_cnt;
    logic sd_q, afull, supply_flag, next_afull, next_supply_flag;
    logic [7:0] next_rdata;
    logic srst_done, status_rd, sd_enter, afull_hit, tick;
    logic [5:0] afull_level;

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    assign srst_done = mode_one[oac_pkg::BIT_SOFT_RESET] && (srst_cnt == 4'(SRST_HOLD - 1));
    // Shutdown still takes writes; soft reset blocks them
    always_comb begin
        next_fifo_cfg = fifo_cfg;
        next_mode_one = mode_one;
        next_mode_two = mode_two;
        next_emit_span = emit_span;
        next_low_pwr_amp = low_pwr_amp;
        next_seq_one = seq_one;
        next_seq_two = seq_two;
        next_amp = amp;
        next_srst_cnt = 4'h0;
        if (mode_one[oac_pkg::BIT_SOFT_RESET]) begin
            next_srst_cnt = srst_cnt + 4'h1;
        end
        // RULE4: restore reset values
        if (srst_done) begin
            next_fifo_cfg = oac_pkg::FIFO_CFG_RST;
            // RULE5: bit drops with the rest
            next_mode_one = oac_pkg::REG_RST;
            next_mode_two = oac_pkg::REG_RST;
            next_emit_span = oac_pkg::REG_RST;
            next_low_pwr_amp = oac_pkg::REG_RST;
            next_seq_one = oac_pkg::REG_RST;
            next_seq_two = oac_pkg::REG_RST;
            next_srst_cnt = 4'h0;
            for (int i = 0; i < 4; i++) begin
                next_amp[i] = oac_pkg::REG_RST;
            end
        // RULE2: writes accepted in power-save
        end else if (reg_wr_in && !mode_one[oac_pkg::BIT_SOFT_RESET]) begin
            case (reg_addr_in)
                oac_pkg::OFS_FIFO_CFG: next_fifo_cfg = reg_wdata_in;
                oac_pkg::OFS_MODE_ONE: next_mode_one = reg_wdata_in & oac_pkg::MODE_ONE_WMASK;
                oac_pkg::OFS_MODE_TWO: next_mode_two = reg_wdata_in;
                oac_pkg::OFS_EMIT_SPAN: next_emit_span = reg_wdata_in;
                oac_pkg::OFS_LOW_PWR_AMP: next_low_pwr_amp = reg_wdata_in;
                oac_pkg::OFS_SEQ_ONE: next_seq_one = reg_wdata_in;
                oac_pkg::OFS_SEQ_TWO: next_seq_two = reg_wdata_in;
                default: begin
                    for (int i = 0; i < 4; i++) begin
                        if (reg_addr_in == oac_pkg::OFS_EMIT1_AMP + 8'(i)) begin
                            next_amp[i] = reg_wdata_in;
                        end
                    end
                end
            endcase
        end
    end

    // Register stage
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            fifo_cfg <= oac_pkg::FIFO_CFG_RST;
            mode_one <= oac_pkg::REG_RST;
            mode_two <= oac_pkg::REG_RST;
            emit_span <= oac_pkg::REG_RST;
            low_pwr_amp <= oac_pkg::REG_RST;
            seq_one <= oac_pkg::REG_RST;
            seq_two <= oac_pkg::REG_RST;
            srst_cnt <= 4'h0;
            for (int i = 0; i < 4; i++) begin
                amp[i] <= oac_pkg::REG_RST;
            end
        end else begin
            fifo_cfg <= next_fifo_cfg;
            mode_one <= next_mode_one;
            mode_two <= next_mode_two;
            emit_span <= next_emit_span;
            low_pwr_amp <= next_low_pwr_amp;
            seq_one <= next_seq_one;
            seq_two <= next_seq_two;
            srst_cnt <= next_srst_cnt;
            amp <= next_amp;
        end
    end

    // ------------------------------------------------------------
    // Flags and read-back
    // ------------------------------------------------------------
    assign status_rd = reg_rd_in && (reg_addr_in == oac_pkg::OFS_IRQ_STATUS);
    assign sd_enter = mode_one[oac_pkg::BIT_SHUTDOWN] && !sd_q;
    // RULE1: threshold is depth minus level
    assign afull_level = oac_pkg::FIFO_DEPTH - {2'b00, fifo_cfg[3:0]};
    assign afull_hit = (fifo_count_in >= afull_level) && !mode_one[oac_pkg::BIT_SHUTDOWN];
    // Set beats clear so an event in the clearing cycle survives
    always_comb begin
        next_afull = afull;
        next_supply_flag = supply_flag;
        // RULE14: read of status clears
        // RULE3: entry to power-save clears
        if (status_rd || sd_enter) begin
            next_afull = 1'b0;
            next_supply_flag = 1'b0;
        end
        if (afull_hit) begin
            next_afull = 1'b1;
        end
        if (supply_low_in) begin
            next_supply_flag = 1'b1;
        end
        next_rdata = 8'h00;
        case (reg_addr_in)
            oac_pkg::OFS_IRQ_STATUS: next_rdata = {afull, 6'h00, supply_flag};
            oac_pkg::OFS_FIFO_CFG: next_rdata = fifo_cfg;
            oac_pkg::OFS_MODE_ONE: next_rdata = mode_one;
            oac_pkg::OFS_MODE_TWO: next_rdata = mode_two;
            oac_pkg::OFS_EMIT_SPAN: next_rdata = emit_span;
            oac_pkg::OFS_LOW_PWR_AMP: next_rdata = low_pwr_amp;
            oac_pkg::OFS_SEQ_ONE: next_rdata = seq_one;
            oac_pkg::OFS_SEQ_TWO: next_rdata = seq_two;
            default: begin
                for (int i = 0; i < 4; i++) begin
                    if (reg_addr_in == oac_pkg::OFS_EMIT1_AMP + 8'(i)) begin
                        next_rdata = amp[i];
                    end
                end
            end
        endcase
    end

    // Of the two resets, only the pin reset touches the supply flag
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            afull <= 1'b0;
            supply_flag <= oac_pkg::SUPPLY_FLAG_RST;
            sd_q <= 1'b0;
            reg_rdata_out <= 8'h00;
            afull_flag_out <= 1'b0;
            supply_ok_flag_out <= oac_pkg::SUPPLY_FLAG_RST;
            osc_run_out <= 1'b0;
            ambient_cancel_loop_out <= 1'b1;
            filter_en_out <= 1'b1;
            converter_span_sel_out <= 2'h0;
        end else begin
            afull <= next_afull;
            supply_flag <= next_supply_flag;
            sd_q <= mode_one[oac_pkg::BIT_SHUTDOWN];
            reg_rdata_out <= next_rdata;
            afull_flag_out <= next_afull;
            supply_ok_flag_out <= next_supply_flag;
            // RULE3: oscillator stops in power-save
            osc_run_out <= !mode_one[oac_pkg::BIT_SHUTDOWN];
            // RULE6: ambient detect mode
            ambient_cancel_loop_out <= !mode_one[oac_pkg::BIT_AMB_DETECT];
            filter_en_out <= !mode_one[oac_pkg::BIT_AMB_DETECT];
            // RULE8: span code to converter
            converter_span_sel_out <= mode_two[6:5];
        end
    end

    // ------------------------------------------------------------
    // Slot sequencer
    // ------------------------------------------------------------
    oac_pkg::oac_state_t st, next_st;
    logic [1:0] slot, next_slot;
    logic [15:0] pcnt, next_pcnt, pulse_cyc, integ_cyc;
    logic [3:0] code, lane;
    logic [3:0] next_emit_on;
    logic [7:0] next_amp_out;
    logic [1:0] next_span_out;
    logic next_integ, next_valid, run, low_pwr;
    logic [3:0] slot_code [4];

    assign run = !mode_one[oac_pkg::BIT_SHUTDOWN] && !mode_one[oac_pkg::BIT_SOFT_RESET]
                 && (mode_one[1:0] != oac_pkg::MODE_OFF);

    oac_rate_timer #(
        .CLK_HZ(CLK_MHZ * 1000000)
    ) u_rate (
        .sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in),
        .run_in(run),
        .rate_sel_in(mode_two[4:2]),
        .tick_out(tick)
    );

    // RULE7: slot list per mode
    // RULE15: flex mode reads the slot fields
    always_comb begin
        slot_code[0] = oac_pkg::SLOT_EMIT1;
        slot_code[1] = (mode_one[1:0] == oac_pkg::MODE_DUAL) ? oac_pkg::SLOT_EMIT2
                                                              : oac_pkg::SLOT_OFF;
        slot_code[2] = oac_pkg::SLOT_OFF;
        slot_code[3] = oac_pkg::SLOT_OFF;
        if (mode_one[1:0] == oac_pkg::MODE_FLEX) begin
            slot_code[0] = seq_one[3:0];
            slot_code[1] = seq_one[7:4];
            slot_code[2] = seq_two[3:0];
            slot_code[3] = seq_two[7:4];
        end
    end

    // RULE11: width and integration cycles
    assign pulse_cyc = 16'(oac_pkg::PULSE_US[mode_two[1:0]] * CLK_MHZ);
    assign integ_cyc = 16'(oac_pkg::INTEG_US[mode_two[1:0]] * CLK_MHZ);
    assign code = slot_code[slot];
    assign low_pwr = (code > oac_pkg::SLOT_LAST_DIRECT) && (code <= oac_pkg::SLOT_LAST_LOW_PWR);
    assign lane = low_pwr ? code - oac_pkg::SLOT_LAST_DIRECT : code;

    // Next state and drive
    always_comb begin
        next_st = st;
        next_slot = slot;
        next_pcnt = pcnt;
        next_emit_on = 4'h0;
        next_amp_out = 8'h00;
        next_span_out = 2'h0;
        next_integ = 1'b0;
        next_valid = 1'b0;
        case (st)
            oac_pkg::OAC_IDLE: begin
                next_slot = 2'h0;
                next_pcnt = 16'h0000;
                if (tick && run) begin
                    next_st = oac_pkg::OAC_PULSE;
                end
            end
            oac_pkg::OAC_PULSE: begin
                if (!run || code == oac_pkg::SLOT_OFF || code > oac_pkg::SLOT_LAST_LOW_PWR) begin
                    next_st = run ? oac_pkg::OAC_NEXT : oac_pkg::OAC_IDLE;
                end else if (pcnt == pulse_cyc - 16'h0001) begin
                    // RULE12: full-width result at pulse end
                    next_valid = 1'b1;
                    next_st = oac_pkg::OAC_NEXT;
                end else begin
                    next_pcnt = pcnt + 16'h0001;
                    // RULE13: direct or low-power amplitude
                    next_emit_on = 4'h1 << (lane - 4'h1);
                    next_amp_out = low_pwr ? low_pwr_amp : amp[2'(lane - 4'h1)];
                    next_span_out = emit_span[2 * (lane - 4'h1) +: 2];
                    next_integ = (pcnt >= pulse_cyc - integ_cyc);
                end
            end
            oac_pkg::OAC_NEXT: begin
                next_pcnt = 16'h0000;
                next_slot = slot + 2'h1;
                next_st = (slot == 2'h3) ? oac_pkg::OAC_IDLE : oac_pkg::OAC_PULSE;
            end
            default: next_st = oac_pkg::OAC_IDLE;
        endcase
    end

    // Sequencer registers
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            st <= oac_pkg::OAC_IDLE;
            slot <= 2'h0;
            pcnt <= 16'h0000;
            emitter_on_out <= 4'h0;
            emitter_amplitude_out <= 8'h00;
            emitter_current_span_out <= 2'h0;
            integrate_out <= 1'b0;
            result_valid_out <= 1'b0;
            result_out <= 19'h00000;
        end else begin
            st <= next_st;
            slot <= next_slot;
            pcnt <= next_pcnt;
            emitter_on_out <= next_emit_on;
            emitter_amplitude_out <= next_amp_out;
            emitter_current_span_out <= next_span_out;
            integrate_out <= next_integ;
            result_valid_out <= next_valid;
            if (next_valid) begin
                result_out <= conv_data_in;
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_AFULL_SET: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RULE1
        afull_hit |=> afull_flag_out)
        else $error("almost-full level reached but flag low");
    AST_SD_CLEARS: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RULE3
        sd_enter && !supply_low_in |=> !afull_flag_out && !supply_ok_flag_out)
        else $error("flags survived power-save entry");
    AST_OSC_STOPS: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RULE3
        mode_one[oac_pkg::BIT_SHUTDOWN] |=> !osc_run_out ##1 emitter_on_out == 4'h0)
        else $error("oscillator or emitter active in power-save");
    AST_SRST_CLEARS: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RULE5
        $rose(mode_one[oac_pkg::BIT_SOFT_RESET]) |-> ##SRST_HOLD
        !mode_one[oac_pkg::BIT_SOFT_RESET])
        else $error("soft reset bit did not clear in time");
    AST_SRST_VALUES: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RULE4
        $fell(mode_one[oac_pkg::BIT_SOFT_RESET]) |-> mode_two == oac_pkg::REG_RST
        && fifo_cfg == oac_pkg::FIFO_CFG_RST && amp[0] == oac_pkg::REG_RST)
        else $error("register kept value across soft reset");
    AST_SD_WRITABLE: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RULE2
        mode_one[oac_pkg::BIT_SHUTDOWN] && !mode_one[oac_pkg::BIT_SOFT_RESET] && reg_wr_in
        && reg_addr_in == oac_pkg::OFS_MODE_TWO |=> mode_two == $past(reg_wdata_in))
        else $error("write lost in power-save");
    AST_AMBIENT: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RULE6
        mode_one[oac_pkg::BIT_AMB_DETECT] |=> !ambient_cancel_loop_out && !filter_en_out)
        else $error("loop or filter left on in ambient detect");
    AST_STATUS_CLEAR: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RULE14
        status_rd && !afull_hit ##1 !afull_hit [*2] |-> !afull_flag_out)
        else $error("almost-full flag not cleared by status read");
    AST_MODE_OFF: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RULE7
        st == oac_pkg::OAC_IDLE && mode_one[1:0] == oac_pkg::MODE_OFF |=> emitter_on_out == 4'h0)
        else $error("emitter fired with acquisition disabled");

endmodule

// [verif/oac_host_model.sv]
// Host model driving the register port.
// Assumes one caller at a time.
`timescale 1ns/100ps
module oac_host_model (
    // Clock
    input wire logic sys_clk_in,
    // Register port
    output logic [7:0] reg_addr_out,
    output logic [7:0] reg_wdata_out,
    output logic reg_wr_out,
    output logic reg_rd_out,
    input wire logic [7:0] reg_rdata_in,
    // Captured read
    output logic rd_done_out,
    output logic [7:0] rd_data_out
);
    // Idle bus at time zero
    initial begin
        reg_addr_out = 8'h00;
        reg_wdata_out = 8'h00;
        reg_wr_out = 1'b0;
        reg_rd_out = 1'b0;
        rd_done_out = 1'b0;
        rd_data_out = 8'h00;
    end
    // One-cycle write; stale data inverted so it never matches
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_in);
        #1;
        reg_addr_out = a;
        reg_wdata_out = d;
        reg_wr_out = 1'b1;
        @(posedge sys_clk_in);
        #1;
        reg_wr_out = 1'b0;
        reg_wdata_out = ~d;
    endtask
    // Read data is registered: taken one edge later
    task automatic rd_reg(input logic [7:0] a);
        @(posedge sys_clk_in);
        #1;
        reg_addr_out = a;
        reg_rd_out = 1'b1;
        @(posedge sys_clk_in);
        #1;
        reg_rd_out = 1'b0;
        rd_data_out = reg_rdata_in;
        rd_done_out = 1'b1;
        @(posedge sys_clk_in);
        #1;
        rd_done_out = 1'b0;
    endtask
endmodule

// [verif/oac_acq_ctrl_tb.sv]
// Self-checking bench for acquisition control.
// Assumes CLK_MHZ=1 timing; the host model owns the bus.
`timescale 1ns/100ps
module oac_acq_ctrl_tb;
    logic sys_clk_in, rst_n_in, wr, rdq, supply_low_in, rd_done, osc, loop_en, filt, rv, afull, sok;
    logic [7:0] addr, wdata, rdata, rd_data, amp, a1, a2, lp;
    logic [5:0] fifo_count_in;
    logic [18:0] conv, result;
    logic [3:0] emit;
    logic [1:0] span_out, cur_span;
    logic [7:0] exp_q[$];
    logic [18:0] res_q[$];
    logic [31:0] seed = 32'h1DCE5BFC;
    int n_mismatch, comparisons, cycles;
    oac_host_model oac_host_model_i (.sys_clk_in(sys_clk_in), .reg_addr_out(addr),
        .reg_wdata_out(wdata), .reg_wr_out(wr), .reg_rd_out(rdq), .reg_rdata_in(rdata),
        .rd_done_out(rd_done), .rd_data_out(rd_data));
    oac_acq_ctrl #(.CLK_MHZ(1)) oac_acq_ctrl_i (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rdq),
        .reg_rdata_out(rdata), .fifo_count_in(fifo_count_in), .supply_low_in(supply_low_in),
        .conv_data_in(conv), .osc_run_out(osc), .ambient_cancel_loop_out(loop_en),
        .filter_en_out(filt), .converter_span_sel_out(span_out), .emitter_on_out(emit),
        .emitter_amplitude_out(amp), .emitter_current_span_out(cur_span), .integrate_out(),
        .result_out(result), .result_valid_out(rv), .afull_flag_out(afull),
        .supply_ok_flag_out(sok));
    initial begin
        sys_clk_in = 1'b0;
        forever #20 sys_clk_in = ~sys_clk_in;
    end
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] s);
        comparisons++;
        if (s !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk_in);
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        oac_host_model_i.rd_reg(a);
    endtask
    task automatic wr_r(input logic [7:0] a, input logic [7:0] d);
        oac_host_model_i.wr_reg(a, d);
    endtask
    // Await a slot, check drive, time pulse
    task automatic see_emit(input logic [3:0] on, input logic [7:0] am, input logic [1:0] sp);
        int n = 0;
        while (emit !== on && n < 800) begin
            cyc(1);
            n++;
        end
        chk("emitter on", on, emit);
        chk("amplitude", am, amp);
        chk("current span", sp, cur_span);
        n = 0;
        while (emit === on && n < 500) begin
            cyc(1);
            n++;
        end
        chk("pulse cycles", oac_pkg::PULSE_US[0] - 1, n);
    endtask
    task print_verdict();
        $display("Counts: %0d comparisons, %0d mismatches", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Watcher pops the oldest note
    always @(posedge sys_clk_in) begin
        cycles++;
        if (rd_done === 1'b1) chk("read data", exp_q.pop_front(), rd_data);
        if (rv === 1'b1) chk("result", res_q.pop_front(), result);
        if (cycles > 20000) begin
            n_mismatch++;
            print_verdict();
        end
    end
    initial begin
        rst_n_in = 1'b0;
        fifo_count_in = 6'h00;
        supply_low_in = 1'b0;
        conv = 19'(rnd());
        {a1, a2, lp} = 24'(rnd());
        cyc(10);
        rst_n_in = 1'b1;
        // Reset values, unmapped read, read-clear
        rd(oac_pkg::OFS_MODE_ONE, 8'h00);
        rd(oac_pkg::OFS_FIFO_CFG, 8'h0F);
        rd(8'h30, 8'h00);
        rd(oac_pkg::OFS_IRQ_STATUS, 8'h01);
        rd(oac_pkg::OFS_IRQ_STATUS, 8'h00);
        for (int i = 0; i < 3; i++) begin
            wr_r(oac_pkg::OFS_MODE_TWO, 8'(rnd()) & 8'h7F);
            cyc(2);
            rd(oac_pkg::OFS_MODE_TWO, wdata ^ 8'hFF);
            chk("span sel", 2'((wdata ^ 8'hFF) >> 5), span_out);
        end
        wr_r(oac_pkg::OFS_MODE_ONE, 8'h04);
        cyc(2);
        chk("cancel loop", 1'b0, loop_en);
        chk("filter", 1'b0, filt);
        wr_r(oac_pkg::OFS_MODE_ONE, 8'h00);
        $display("test registers done");
        // Almost-full at both level extremes
        for (int lv = 0; lv < 16; lv += 15) begin
            wr_r(oac_pkg::OFS_FIFO_CFG, 8'(lv));
            fifo_count_in = 6'(31 - lv);
            cyc(2);
            chk("afull below", 1'b0, afull);
            fifo_count_in = 6'(32 - lv);
            cyc(2);
            chk("afull at", 1'b1, afull);
            fifo_count_in = 6'h00;
            cyc(2);
            rd(oac_pkg::OFS_IRQ_STATUS, 8'h80);
            rd(oac_pkg::OFS_IRQ_STATUS, 8'h00);
        end
        $display("test almost full done");
        // Shutdown clears flags, keeps registers
        fifo_count_in = 6'h20;
        cyc(2);
        wr_r(oac_pkg::OFS_MODE_ONE, 8'h80);
        cyc(3);
        chk("osc run", 1'b0, osc);
        chk("afull in shutdown", 1'b0, afull);
        wr_r(oac_pkg::OFS_EMIT1_AMP, 8'h3C);
        rd(oac_pkg::OFS_EMIT1_AMP, 8'h3C);
        rd(oac_pkg::OFS_MODE_ONE, 8'h80);
        fifo_count_in = 6'h00;
        wr_r(oac_pkg::OFS_MODE_ONE, 8'h00);
        cyc(2);
        chk("osc run", 1'b1, osc);
        $display("test shutdown done");
        // Soft reset keeps the supply flag
        supply_low_in = 1'b1;
        cyc(1);
        supply_low_in = 1'b0;
        wr_r(oac_pkg::OFS_MODE_TWO, 8'h25);
        wr_r(oac_pkg::OFS_MODE_ONE, 8'h40);
        rd(oac_pkg::OFS_MODE_ONE, 8'h40);
        cyc(10);
        rd(oac_pkg::OFS_MODE_ONE, 8'h00);
        rd(oac_pkg::OFS_MODE_TWO, 8'h00);
        rd(oac_pkg::OFS_EMIT1_AMP, 8'h00);
        rd(oac_pkg::OFS_FIFO_CFG, 8'h0F);
        rd(oac_pkg::OFS_IRQ_STATUS, 8'h01);
        $display("test soft reset done");
        // Each active mode at 1600 sps, legal for two short pulses
        wr_r(oac_pkg::OFS_EMIT1_AMP, a1);
        wr_r(8'h0D, a2);
        wr_r(oac_pkg::OFS_LOW_PWR_AMP, lp);
        wr_r(oac_pkg::OFS_EMIT_SPAN, 8'h06);
        wr_r(oac_pkg::OFS_SEQ_ONE, 8'h52);
        wr_r(oac_pkg::OFS_MODE_TWO, 8'h18);
        for (int m = 1; m < 4; m++) begin
            res_q.push_back(conv);
            if (m > 1) res_q.push_back(conv);
            wr_r(oac_pkg::OFS_MODE_ONE, 8'(m));
            see_emit(m == 3 ? 4'h2 : 4'h1, m == 3 ? a2 : a1, m == 3 ? 2'h1 : 2'h2);
            if (m > 1) see_emit(m == 3 ? 4'h1 : 4'h2, m == 3 ? lp : a2, m == 3 ? 2'h2 : 2'h1);
            cyc(20);
            wr_r(oac_pkg::OFS_MODE_ONE, 8'h00);
        end
        cyc(5);
        $display("test sequencing done");
        print_verdict();
    end
endmodule
